// ===== verilog/csir_core_regs.v
// core status, option and interrupt register bank
// Operation
// - indirect bank bit picks upper or lower memory half, indirect only
// - two direct bank bits select banks 0 to 3 for direct access
// - timeout bit set at power-up, clear-watchdog, sleep; cleared on timeout
// - power-down bit set at power-up and clear-watchdog; cleared by sleep
// - zero flag follows whether the alu result is zero, except on rotates
// - digit carry is carry out of bit 3; borrow inverted on subtract, but zero if subtrahend is nonzero with low nibble 0
// - carry is carry out of bit 7; borrow inverted on subtract
// - subtract adds two's complement; rotates load carry from source end bit
// - pull-up disable bit kills all port-b pull-ups, else per latch
// - external interrupt on rising edge when edge bit one, else falling
// - timer0 counts instruction clock or chosen edge of external clock pin
// - prescaler to watchdog or timer0; timer0 undivided when watchdog owns
// - rate n divides timer0 by 2^(n+1), watchdog by 2^n
// - flags set on their event regardless of any enable
// - global enable gates every interrupt
// - peripheral enable gates all peripheral interrupts
// - separate enables for timer0, external pin and port change
// - timer0 and external flags set by hardware, cleared by software only
// - port change flag set on upper port-b change, software clears
// - peripheral enable register, bits 5 and 4 read zero
// - peripheral flags set on their events, software clears
// - capture/compare flag set on capture or compare match, unused in pwm
// - alu-affected flag writes ignored only in a cycle with an alu op; timeout, power-down never writable
`timescale 1ns/1ps
`default_nettype none
`include "csir_defs.vh"
module csir_core_regs (
  // clock, reset, enable
  input  wire       i_core_clk,
  input  wire       i_nrst,
  input  wire       i_ce,
  // register port
  input  wire [8:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  // alu
  input  wire [2:0] i_alu_op,
  input  wire [7:0] i_alu_a,
  input  wire [7:0] i_alu_b,
  output reg  [7:0] o_alu_result,
  // cpu events
  input  wire       i_clear_watchdog_instruction,
  input  wire       i_sleep,
  input  wire       i_wdt_timeout,
  input  wire       i_wdt_osc_tick,
  // addressing
  input  wire [7:0] i_fsr,
  input  wire [6:0] i_dir_addr,
  output reg  [8:0] o_ind_addr,
  output reg  [8:0] o_dir_addr,
  // pins
  input  wire       i_ext_int_pin,
  input  wire       i_t0_ext_clk_pin,
  input  wire [3:0] i_upper_port_b_a_pins,
  input  wire [7:0] i_port_b_a_latch,
  output reg  [7:0] o_port_b_a_pullup_en,
  // peripheral events
  input  wire       i_timer0_overflow,
  input  wire       i_lcd_event,
  input  wire       i_conv_done,
  input  wire       i_serial_done,
  input  wire [1:0] i_ccp_mode,
  input  wire       i_timer1_capture,
  input  wire       i_timer1_compare,
  input  wire       i_timer2_match,
  input  wire       i_timer1_overflow,
  // outputs
  output reg        o_timer0_tick,
  output reg        o_wdt_tick,
  output reg        o_int_req
);
  ////////////////////////////////////////////////////////////////////////////
  reg [7:0] status_q;
  reg [7:0] option_q;
  reg [7:0] core_interrupt_control_q;
  reg [7:0] pir_q;
  reg [7:0] pie_q;
  reg       ext_pin_q;
  reg [3:0] rb_q;
  wire [7:0] alu_res;
  wire      alu_z;
  wire      alu_dc;
  wire      alu_c;
  wire      t0_tick;
  wire      wd_tick;

  function hit;
    input [8:0] a;
    input [8:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  wire wr_status = i_wr & hit(i_addr, `CSIR_OFF_STATUS);
  wire wr_option = i_wr & hit(i_addr, `CSIR_OFF_OPTCFG);
  wire wr_core_interrupt_control = i_wr & hit(i_addr, `CSIR_OFF_INTCTL);
  wire wr_pir    = i_wr & hit(i_addr, `CSIR_OFF_PFLAGS);
  wire wr_pie    = i_wr & hit(i_addr, `CSIR_OFF_PENABLE);
  wire alu_act   = (i_alu_op != `CSIR_OP_NONE);
  wire arith     = (i_alu_op == `CSIR_OP_ADD) | (i_alu_op == `CSIR_OP_SUB);
  wire rot       = (i_alu_op == `CSIR_OP_RRF) | (i_alu_op == `CSIR_OP_RLF);

  ////////////////////////////////////////////////////////////////////////////
  csir_alu_flags u_alu (
    .i_op     (i_alu_op),
    .i_a      (i_alu_a),
    .i_b      (i_alu_b),
    .i_carry  (status_q[`CSIR_B_C]),
    .o_result (alu_res),
    .o_z      (alu_z),
    .o_dc     (alu_dc),
    .o_c      (alu_c)
  );

  csir_prescaler u_pre (
    .i_core_clk   (i_core_clk),
    .i_nrst       (i_nrst),
    .i_ce         (i_ce),
    .i_cfg        (option_q),
    .i_t0_ext_pin (i_t0_ext_clk_pin),
    .i_wdt_tick   (i_wdt_osc_tick),
    .i_clear      (i_clear_watchdog_instruction | wr_option),
    .o_t0_tick    (t0_tick),
    .o_wdt_tick   (wd_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // event detection
  wire ext_edge = option_q[`CSIR_B_EXT_INT_EDGE_SELECT] ? (~ext_pin_q & i_ext_int_pin)
                                           : (ext_pin_q & ~i_ext_int_pin);
  wire rb_chg   = |(rb_q ^ i_upper_port_b_a_pins);
  wire ccp_ev   = (i_ccp_mode == `CSIR_CCP_CAPTURE) ? i_timer1_capture
                : (i_ccp_mode == `CSIR_CCP_COMPARE) ? i_timer1_compare
                : 1'b0;
  wire [7:0] pir_set = {i_lcd_event, i_conv_done, 2'b00, i_serial_done,
                        ccp_ev, i_timer2_match, i_timer1_overflow};
  wire [7:0] int_set = {5'h00, i_timer0_overflow, ext_edge, rb_chg};

  ////////////////////////////////////////////////////////////////////////////
  // register updates
  reg [7:0] status_d;
  reg [7:0] core_interrupt_control_d;
  reg [7:0] pir_d;
  always @* begin
    status_d = status_q;
    if (wr_status) begin
      status_d[7:5] = i_wdata[7:5];
      if (!alu_act) begin
        status_d[2:0] = i_wdata[2:0];
      end
    end
    if (arith) begin
      status_d[`CSIR_B_DC] = alu_dc;
      status_d[`CSIR_B_C]  = alu_c;
    end
    if (rot) begin
      status_d[`CSIR_B_C] = alu_c;
    end
    if (alu_act && !rot) begin
      status_d[`CSIR_B_Z] = alu_z;
    end
    if (i_clear_watchdog_instruction) begin
      status_d[`CSIR_B_TO] = 1'b1;
      status_d[`CSIR_B_PD] = 1'b1;
    end else if (i_sleep) begin
      status_d[`CSIR_B_TO] = 1'b1;
      status_d[`CSIR_B_PD] = 1'b0;
    end
    if (i_wdt_timeout) begin
      status_d[`CSIR_B_TO] = 1'b0;
    end
    core_interrupt_control_d = wr_core_interrupt_control ? i_wdata : core_interrupt_control_q;
    core_interrupt_control_d = core_interrupt_control_d | int_set;
    pir_d    = wr_pir ? (i_wdata & `CSIR_PIR_MASK) : pir_q;
    pir_d    = pir_d | pir_set;
  end

  wire core_pend = |(core_interrupt_control_q[5:3] & core_interrupt_control_q[2:0]);
  wire peri_pend = core_interrupt_control_q[`CSIR_B_PERIPHERAL_INT_ENABLE] & |(pie_q & pir_q);
  wire irq       = core_interrupt_control_q[`CSIR_B_GIE] & (core_pend | peri_pend);

  reg [7:0] rd_mux;
  always @* begin
    case (i_addr)
      `CSIR_OFF_STATUS:  rd_mux = status_q;
      `CSIR_OFF_OPTCFG:  rd_mux = option_q;
      `CSIR_OFF_INTCTL:  rd_mux = core_interrupt_control_q;
      `CSIR_OFF_PFLAGS:  rd_mux = pir_q;
      `CSIR_OFF_PENABLE: rd_mux = pie_q;
      default:           rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_q          <= `CSIR_RST_STATUS;
      option_q          <= `CSIR_RST_OPTCFG;
      core_interrupt_control_q          <= `CSIR_RST_INTCTL;
      pir_q             <= `CSIR_RST_PIR;
      pie_q             <= `CSIR_RST_PIR;
      ext_pin_q         <= 1'b0;
      rb_q              <= 4'h0;
      o_rdata           <= 8'h00;
      o_alu_result      <= 8'h00;
      o_ind_addr        <= 9'h000;
      o_dir_addr        <= 9'h000;
      o_port_b_a_pullup_en <= 8'h00;
      o_timer0_tick     <= 1'b0;
      o_wdt_tick        <= 1'b0;
      o_int_req         <= 1'b0;
    end else if (i_ce) begin
      status_q  <= status_d;
      core_interrupt_control_q  <= core_interrupt_control_d;
      pir_q     <= pir_d;
      ext_pin_q <= i_ext_int_pin;
      rb_q      <= i_upper_port_b_a_pins;
      if (wr_option) begin
        option_q <= i_wdata;
      end
      if (wr_pie) begin
        pie_q <= i_wdata & `CSIR_PIR_MASK;
      end
      o_rdata      <= i_rd ? rd_mux : 8'h00;
      o_alu_result <= alu_res;
      o_ind_addr   <= {status_q[`CSIR_B_IRP], i_fsr};
      o_dir_addr   <= {status_q[`CSIR_B_RP1:`CSIR_B_RP0], i_dir_addr};
      o_port_b_a_pullup_en <= option_q[`CSIR_B_PUDIS] ? 8'h00
                                                   : ~i_port_b_a_latch;
      o_timer0_tick <= t0_tick;
      o_wdt_tick    <= wd_tick;
      o_int_req     <= irq;
    end
  end
endmodule // csir_core_regs
`default_nettype wire

// ===== verilog/csir_defs.vh
// offsets, field positions, reset values and codes of the core register bank
`ifndef CSIR_DEFS_VH
`define CSIR_DEFS_VH
`define CSIR_ADDR_W        9
`define CSIR_OFF_STATUS    9'h003
`define CSIR_OFF_INTCTL    9'h00b
`define CSIR_OFF_PFLAGS    9'h00c
`define CSIR_OFF_OPTCFG    9'h081
`define CSIR_OFF_PENABLE   9'h08c
`define CSIR_RST_STATUS    8'h18
`define CSIR_RST_OPTCFG    8'hff
`define CSIR_RST_INTCTL    8'h00
`define CSIR_RST_PIR       8'h00
`define CSIR_PIR_MASK      8'hcf
`define CSIR_B_IRP         7
`define CSIR_B_RP1         6
`define CSIR_B_RP0         5
`define CSIR_B_TO          4
`define CSIR_B_PD          3
`define CSIR_B_Z           2
`define CSIR_B_DC          1
`define CSIR_B_C           0
`define CSIR_B_PUDIS       7
`define CSIR_B_EXT_INT_EDGE_SELECT      6
`define CSIR_B_T0SRC       5
`define CSIR_B_T0EDGE      4
`define CSIR_B_PSA         3
`define CSIR_B_GIE         7
`define CSIR_B_PERIPHERAL_INT_ENABLE        6
`define CSIR_B_T0IE        5
`define CSIR_B_EXTIE       4
`define CSIR_B_PCIE        3
`define CSIR_B_T0IF        2
`define CSIR_B_EXTIF       1
`define CSIR_B_PCIF        0
`define CSIR_B_CCPF        2
`define CSIR_OP_NONE       3'h0
`define CSIR_OP_ADD        3'h1
`define CSIR_OP_SUB        3'h2
`define CSIR_OP_LOGIC      3'h3
`define CSIR_OP_RRF        3'h4
`define CSIR_OP_RLF        3'h5
`define CSIR_CCP_CAPTURE   2'h0
`define CSIR_CCP_COMPARE   2'h1
`define CSIR_CCP_PWM       2'h2
`endif

// ===== verilog/csir_alu_flags.v
// add, subtract and rotate flag generator for the status register
`timescale 1ns/1ps
`default_nettype none
`include "csir_defs.vh"
module csir_alu_flags (
  // operation
  input  wire [2:0] i_op,
  input  wire [7:0] i_a,
  input  wire [7:0] i_b,
  input  wire       i_carry,
  // results
  output reg  [7:0] o_result,
  output reg        o_z,
  output reg        o_dc,
  output reg        o_c
);
  reg [8:0] sum;
  reg [4:0] low;
  reg [7:0] opb;
  always @* begin
    sum      = 9'h000;
    low      = 5'h00;
    opb      = i_b;
    o_result = i_a;
    o_z      = 1'b0;
    o_dc     = 1'b0;
    o_c      = i_carry;
    case (i_op)
      `CSIR_OP_ADD, `CSIR_OP_SUB: begin
        if (i_op == `CSIR_OP_SUB) begin
          opb = ~i_b + 8'h01;
        end
        sum      = {1'b0, i_a} + {1'b0, opb};
        low      = {1'b0, i_a[3:0]} + {1'b0, opb[3:0]};
        if (i_op == `CSIR_OP_SUB && i_b == 8'h00) begin
          sum = 9'h100 | {1'b0, i_a};
          low = 5'h10 | {1'b0, i_a[3:0]};
        end
        o_result = sum[7:0];
        o_dc     = low[4];
        o_c      = sum[8];
      end
      `CSIR_OP_RRF: begin
        o_result = {i_carry, i_a[7:1]};
        o_c      = i_a[0];
      end
      `CSIR_OP_RLF: begin
        o_result = {i_a[6:0], i_carry};
        o_c      = i_a[7];
      end
      default: begin
        o_result = i_a;
      end
    endcase
    o_z = (o_result == 8'h00);
  end
endmodule // csir_alu_flags
`default_nettype wire

// ===== verilog/csir_prescaler.v
// shared timer0 / watchdog prescaler with source and edge selection
`timescale 1ns/1ps
`default_nettype none
`include "csir_defs.vh"
module csir_prescaler (
  // clock and reset
  input  wire       i_core_clk,
  input  wire       i_nrst,
  input  wire       i_ce,
  // configuration
  input  wire [7:0] i_cfg,
  // sources
  input  wire       i_t0_ext_pin,
  input  wire       i_wdt_tick,
  input  wire       i_clear,
  // ticks
  output reg        o_t0_tick,
  output reg        o_wdt_tick
);
  reg       pin_q;
  reg [7:0] cnt_q;
  wire      src_int  = ~i_cfg[`CSIR_B_T0SRC];
  wire      ext_edge = i_cfg[`CSIR_B_T0EDGE] ? (pin_q & ~i_t0_ext_pin)
                                             : (~pin_q & i_t0_ext_pin);
  wire      t0_raw   = src_int | ext_edge;
  wire      prescaler_assign      = i_cfg[`CSIR_B_PSA];
  wire      pre_in   = prescaler_assign ? i_wdt_tick : t0_raw;
  wire [3:0] shift   = prescaler_assign ? {1'b0, i_cfg[2:0]}
                           : {1'b0, i_cfg[2:0]} + 4'h1;
  wire [8:0] full    = 9'h001 << shift;
  wire [7:0] nxt     = cnt_q + 8'h01;
  wire      wrap     = (shift == 4'h0) ? 1'b1
                     : (({1'b0, cnt_q} + 9'h001) == full);
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_q      <= 1'b0;
      cnt_q      <= 8'h00;
      o_t0_tick  <= 1'b0;
      o_wdt_tick <= 1'b0;
    end else if (i_ce) begin
      pin_q      <= i_t0_ext_pin;
      o_t0_tick  <= prescaler_assign ? t0_raw : 1'b0;
      o_wdt_tick <= prescaler_assign ? 1'b0 : i_wdt_tick;
      if (i_clear) begin
        cnt_q <= 8'h00;
      end else if (pre_in) begin
        cnt_q <= wrap ? 8'h00 : nxt;
        if (wrap && prescaler_assign) begin
          o_wdt_tick <= 1'b1;
        end
        if (wrap && !prescaler_assign) begin
          o_t0_tick <= 1'b1;
        end
      end
    end
  end
endmodule // csir_prescaler
`default_nettype wire

// ===== verif/csir_core_regs_asserts.sv
// assertion checker for the core register bank
`timescale 1ns/1ps
`default_nettype none
`include "csir_defs.vh"
module csir_core_regs_asserts (
  // clock and reset
  input wire logic       i_core_clk,
  input wire logic       i_nrst,
  input wire logic       i_ce,
  // inputs
  input wire logic [8:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic [2:0] i_alu_op,
  input wire logic [7:0] i_alu_a,
  input wire logic [7:0] i_alu_b,
  input wire logic [7:0] i_fsr,
  input wire logic [6:0] i_dir_addr,
  input wire logic       i_timer0_overflow,
  // outputs
  input wire logic [7:0] o_alu_result,
  input wire logic [8:0] o_ind_addr,
  input wire logic [8:0] o_dir_addr,
  input wire logic [7:0] o_port_b_a_pullup_en,
  input wire logic       o_timer0_tick,
  input wire logic       o_int_req
);
  ////////////////////////////////////////
  // shadow of software-owned bits
  logic [2:0] bank_q;
  logic [7:0] ic_q;
  logic [7:0] opt_q;
  logic       t0_direct;
  assign t0_direct = !opt_q[5] && opt_q[3];
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bank_q <= 3'h0;
      ic_q   <= 8'h00;
      opt_q  <= 8'hff;
    end else if (i_wr && i_ce) begin
      if (i_addr == `CSIR_OFF_STATUS) bank_q <= i_wdata[7:5];
      if (i_addr == `CSIR_OFF_INTCTL) ic_q <= i_wdata;
      if (i_addr == `CSIR_OFF_OPTCFG) opt_q <= i_wdata;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);
  a_pullup_off: assert property (
    opt_q[7] && $past(opt_q[7]) |-> o_port_b_a_pullup_en == 8'h00)
    else $error("pullups on while disabled");
  a_ind_addr: assert property ($past(i_nrst) |->
    o_ind_addr == {$past(bank_q[2]), $past(i_fsr)})
    else $error("indirect address wrong");
  a_dir_addr: assert property ($past(i_nrst) |->
    o_dir_addr == {$past(bank_q[1:0]), $past(i_dir_addr)})
    else $error("direct address wrong");
  a_add_result: assert property ($past(i_alu_op) == `CSIR_OP_ADD |->
    o_alu_result == $past(i_alu_a) + $past(i_alu_b))
    else $error("add result wrong");
  a_sub_result: assert property ($past(i_alu_op) == `CSIR_OP_SUB |->
    o_alu_result == $past(i_alu_a) + ~$past(i_alu_b) + 8'h01)
    else $error("subtract result wrong");
  a_t0_req: assert property (
    ic_q[7] && ic_q[5] && i_timer0_overflow |-> ##[1:2] o_int_req)
    else $error("no request after overflow");
  a_gie_block: assert property (
    !ic_q[7] && !$past(ic_q[7]) |-> !o_int_req)
    else $error("request with global enable off");
  a_t0_direct: assert property (
    t0_direct && $past(t0_direct, 3) && $past(i_nrst, 3) |-> o_timer0_tick)
    else $error("timer0 not undivided");
endmodule // csir_core_regs_asserts
bind csir_core_regs csir_core_regs_asserts csir_core_regs_asserts_inst (
  .i_core_clk, .i_nrst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_alu_op,
  .i_alu_a, .i_alu_b, .i_fsr, .i_dir_addr, .i_timer0_overflow,
  .o_alu_result, .o_ind_addr, .o_dir_addr, .o_port_b_a_pullup_en,
  .o_timer0_tick, .o_int_req
);
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench for the core register bank
`timescale 1ns/1ps
`default_nettype none
`include "csir_defs.vh"
module tb_top;
  ////////////////////////////////////////
  logic        i_core_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_ext_int_pin = 1'b0;
  logic [8:0]  i_addr = 9'h000;
  logic [7:0]  i_wdata = 8'h00;
  logic [2:0]  i_alu_op = 3'h0;
  logic [7:0]  i_alu_a = 8'h00;
  logic [7:0]  i_alu_b = 8'h00;
  logic [7:0]  i_fsr = 8'h5a;
  logic [6:0]  i_dir_addr = 7'h35;
  logic [3:0]  i_upper_port_b_a_pins = 4'h0;
  logic [7:0]  i_port_b_a_latch = 8'h5a;
  logic [1:0]  i_ccp_mode = `CSIR_CCP_CAPTURE;
  logic [10:0] ev = 11'h000;
  logic [7:0]  o_rdata, o_alu_result, o_port_b_a_pullup_en;
  logic [8:0]  o_ind_addr, o_dir_addr;
  logic        o_timer0_tick, o_wdt_tick, o_int_req;
  int          n_errors = 0;
  int          total_checks = 0;
  localparam logic [8:0] r_st = `CSIR_OFF_STATUS;
  localparam logic [8:0] r_ic = `CSIR_OFF_INTCTL;
  localparam logic [8:0] r_pf = `CSIR_OFF_PFLAGS;
  localparam logic [8:0] r_op = `CSIR_OFF_OPTCFG;
  localparam logic [8:0] r_pe = `CSIR_OFF_PENABLE;
  csir_core_regs csir_core_regs_inst (
    .i_core_clk, .i_nrst, .i_ce(1'b1), .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_alu_op, .i_alu_a, .i_alu_b, .o_alu_result,
    .i_clear_watchdog_instruction(ev[10]), .i_sleep(ev[9]), .i_wdt_timeout(ev[8]),
    .i_wdt_osc_tick(1'b1), .i_fsr, .i_dir_addr, .o_ind_addr, .o_dir_addr,
    .i_ext_int_pin, .i_t0_ext_clk_pin(1'b0), .i_upper_port_b_a_pins,
    .i_port_b_a_latch, .o_port_b_a_pullup_en, .i_timer0_overflow(ev[7]),
    .i_lcd_event(ev[6]), .i_conv_done(ev[5]), .i_serial_done(ev[4]),
    .i_ccp_mode, .i_timer1_capture(ev[3]), .i_timer1_compare(ev[2]),
    .i_timer2_match(ev[1]), .i_timer1_overflow(ev[0]), .o_timer0_tick,
    .o_wdt_tick, .o_int_req
  );
  initial forever #25 i_core_clk = ~i_core_clk;
  ////////////////////////////////////////
  task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [8:0] a, logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(logic [8:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    chk("read data", {1'b0, e & m}, {1'b0, o_rdata & m});
  endtask
  task automatic pulse(logic [10:0] m);
    @(posedge i_core_clk);
    ev <= m;
    @(posedge i_core_clk);
    ev <= 11'h000;
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask
  task automatic alu(logic [2:0] op, logic [7:0] a, b, r, logic [2:0] f, m);
    @(posedge i_core_clk);
    i_alu_op <= op;
    i_alu_a <= a;
    i_alu_b <= b;
    @(posedge i_core_clk);
    i_alu_op <= `CSIR_OP_NONE;
    @(negedge i_core_clk);
    chk("alu result", {1'b0, r}, {1'b0, o_alu_result});
    rd(r_st, {5'h03, f}, {5'h1f, m});
  endtask
  task automatic count(logic [7:0] cfg, int et, int ew);
    int nt = 0;
    int nw = 0;
    wr(r_op, cfg);
    wt(4);
    repeat (32) begin
      nt += (o_timer0_tick === 1'b1);
      nw += (o_wdt_tick === 1'b1);
      @(negedge i_core_clk);
    end
    chk("timer0 ticks", et[8:0], nt[8:0]);
    chk("watchdog ticks", ew[8:0], nw[8:0]);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    rd(r_st, 8'h18);
    rd(r_op, 8'hff);
    rd(r_ic, 8'h00);
    rd(r_pe, 8'h00);
    rd(9'h1ff, 8'h00);
    chk("pullups", 9'h000, {1'b0, o_port_b_a_pullup_en});
  endtask
  task automatic t_status;
    wr(r_st, 8'hff);
    rd(r_st, 8'hff);
    chk("ind addr", {1'b1, i_fsr}, o_ind_addr);
    chk("dir addr", {2'b11, i_dir_addr}, o_dir_addr);
    wr(r_st, 8'h40);
    rd(r_st, 8'h58);
    chk("ind addr", {1'b0, i_fsr}, o_ind_addr);
    chk("dir addr", {2'b10, i_dir_addr}, o_dir_addr);
    pulse(11'h200);
    rd(r_st, 8'h50);
    pulse(11'h100);
    rd(r_st, 8'h40);
    pulse(11'h400);
    rd(r_st, 8'h58);
    wr(r_st, 8'h00);
  endtask
  task automatic t_alu;
    alu(`CSIR_OP_ADD, 8'h0f, 8'h01, 8'h10, 3'b010, 3'h7);
    alu(`CSIR_OP_ADD, 8'hff, 8'h01, 8'h00, 3'b111, 3'h7);
    alu(`CSIR_OP_ADD, 8'h80, 8'h80, 8'h00, 3'b101, 3'h7);
    alu(`CSIR_OP_SUB, 8'h05, 8'h05, 8'h00, 3'b111, 3'h7);
    alu(`CSIR_OP_SUB, 8'h00, 8'h01, 8'hff, 3'b000, 3'h7);
    alu(`CSIR_OP_SUB, 8'h10, 8'h01, 8'h0f, 3'b001, 3'h7);
    alu(`CSIR_OP_RRF, 8'h01, 8'h00, 8'h80, 3'b001, 3'h1);
    alu(`CSIR_OP_RLF, 8'h00, 8'h00, 8'h01, 3'b000, 3'h1);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= r_st;
    i_wdata <= 8'h07;
    i_alu_op <= `CSIR_OP_ADD;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    i_alu_op <= `CSIR_OP_NONE;
    rd(r_st, 8'h1c);
  endtask
  task automatic t_flags;
    wr(r_pe, 8'hff);
    rd(r_pe, 8'hcf);
    wr(r_pf, 8'h30);
    rd(r_pf, 8'h00);
    pulse(11'h0ff);
    rd(r_pf, 8'hcf);
    rd(r_ic, 8'h04);
    chk("int req", 9'h000, {8'h00, o_int_req});
    wr(r_ic, 8'hc4);
    wt(2);
    chk("int req", 9'h001, {8'h00, o_int_req});
    wr(r_ic, 8'h84);
    wt(2);
    chk("int req", 9'h000, {8'h00, o_int_req});
    wr(r_ic, 8'ha4);
    wt(2);
    chk("int req", 9'h001, {8'h00, o_int_req});
    wr(r_ic, 8'h24);
    wt(2);
    chk("int req", 9'h000, {8'h00, o_int_req});
    wr(r_ic, 8'ha0);
    pulse(11'h080);
    wt(2);
    chk("int req", 9'h001, {8'h00, o_int_req});
    rd(r_ic, 8'ha4);
    wr(r_ic, 8'h00);
    wr(r_pf, 8'h00);
    i_ccp_mode <= `CSIR_CCP_PWM;
    pulse(11'h00c);
    rd(r_pf, 8'h00);
    i_ccp_mode <= `CSIR_CCP_COMPARE;
    pulse(11'h004);
    rd(r_pf, 8'h04);
  endtask
  task automatic t_pins;
    wr(r_op, 8'h40);
    wt(2);
    chk("pullups", 9'h0a5, {1'b0, o_port_b_a_pullup_en});
    wr(r_ic, 8'h90);
    i_ext_int_pin <= 1'b1;
    wt(2);
    chk("int req", 9'h001, {8'h00, o_int_req});
    wr(r_ic, 8'h10);
    i_ext_int_pin <= 1'b0;
    rd(r_ic, 8'h10);
    wr(r_op, 8'h00);
    i_ext_int_pin <= 1'b1;
    rd(r_ic, 8'h10);
    i_ext_int_pin <= 1'b0;
    rd(r_ic, 8'h12);
    wr(r_ic, 8'h00);
    i_upper_port_b_a_pins <= 4'h8;
    rd(r_ic, 8'h01);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    t_reset;
    t_status;
    t_alu;
    t_flags;
    t_pins;
    count(8'h8a, 32, 8);
    count(8'h88, 32, 32);
    count(8'h01, 8, 32);
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
